// >>> pllsw_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * reference clock switchover block.
 * assumes: included by bare name from the package and the design module.
 */
`ifndef PLLSW_REGS_SVH
`define PLLSW_REGS_SVH

// register byte offsets
`define PLLSW_CTRL_OFS        8'h00
`define PLLSW_STATUS_OFS      8'h04
`define PLLSW_IRQ_STAT_OFS    8'h08
`define PLLSW_IRQ_MASK_OFS    8'h0c

// control: switchover delay in reference cycles, bits 7:0
`define PLLSW_CTRL_DLY_LSB    0
`define PLLSW_CTRL_DLY_W      8
`define PLLSW_CTRL_RST        8'h00

// status fields
`define PLLSW_ST_ACTIVE_BIT   0
`define PLLSW_ST_WAIT_BIT     1
`define PLLSW_ST_REQ_BIT      2
`define PLLSW_ST_PRI_OK_BIT   3
`define PLLSW_ST_BAK_OK_BIT   4

// interrupt status and mask fields
`define PLLSW_IRQ_DONE_BIT    0
`define PLLSW_IRQ_STALL_BIT   1
`define PLLSW_IRQ_W           2
`define PLLSW_IRQ_RST         2'h0

// minimum request hold in reference cycles
`define PLLSW_MIN_HOLD        9'h003

// timing: system clock rate and reference activity window
`define PLLSW_CLK_MHZ         200
`define PLLSW_ALIVE_NS        1000
`define PLLSW_ALIVE_CYC       ((`PLLSW_ALIVE_NS * `PLLSW_CLK_MHZ) / 1000)
`define PLLSW_ALIVE_W         8

`endif

// >>> pllsw_pkg.sv
/*
 * types shared by the reference clock switchover block.
 * assumes: pllsw_regs.svh is on the include path.
 */
`include "pllsw_regs.svh"

package pllsw_pkg;

	// switchover sequence states
	typedef enum logic [2:0] {
		PLLSW_ARMED = 3'b000, // waiting for a rising request
		PLLSW_COUNT = 3'b001, // counting held reference cycles
		PLLSW_WAIT  = 3'b010, // target reference not toggling
		PLLSW_GATE  = 3'b011, // waiting falling edge of old input
		PLLSW_SWAP  = 3'b100, // waiting falling edge of new input
		PLLSW_HOLD  = 3'b101  // waiting for the request to drop
	} pllsw_state_e;

	typedef logic [31:0] pllsw_word_t;
	typedef logic [7:0]  pllsw_addr_t;

endpackage

// >>> pllsw_switchover.sv
/*
 * reference clock switchover controller for a phase-locked loop: picks the
 * primary or backup reference, switches on a qualified manual request, and
 * sequences gate-off and multiplexer change glitch-free.
 * assumes: one system clock clk much faster than both references; the
 * references and the request are asynchronous pins; loop reset and output
 * re-enable after a switch are handled by the user logic outside.
 */
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "pllsw_regs.svh"

module pllsw_switchover (
	input  wire logic               clk,               // system clock, 200 MHz
	input  wire logic               rst_n,             // async reset, active low
	input  wire logic               primary_ref_clock, // primary reference pin
	input  wire logic               backup_ref_clock,  // backup reference pin
	input  wire logic               switch_req,        // manual switch request pin
	input  wire pllsw_pkg::pllsw_addr_t reg_addr,      // register byte address
	input  wire pllsw_pkg::pllsw_word_t reg_wdata,     // register write data
	input  wire logic               reg_wr,            // write strobe
	input  wire logic               reg_rd,            // read strobe
	output pllsw_pkg::pllsw_word_t  reg_rdata,         // read data, cycle after strobe
	output logic                    ref_select,        // mux select: 0 primary, 1 backup
	output logic                    ref_gate_en,       // counter reference enable
	output logic                    active_clock,      // active reference status
	output logic                    irq                // level interrupt
);
	import pllsw_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// pick the bit of a primary/backup pair that belongs to a selection
	function automatic logic pick(input logic sel, input logic [1:0] pair);
		pick = sel ? pair[1] : pair[0];
	endfunction

	// decode a register offset against the bus address
	function automatic logic hit(input pllsw_addr_t a, input pllsw_addr_t ofs);
		hit = (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: bit 0 primary, bit 1 backup, bit 2 request

	logic [2:0] sync1_q;   // first stage, read only by second
	logic [2:0] sync2_q;   // second stage, safe to use
	logic [2:0] hist_q;    // one more stage for edge detection
	logic [2:0] sync1_d;
	logic [2:0] sync2_d;
	logic [2:0] hist_d;

	// next values of the synchroniser chain
	always_comb begin
		sync1_d = {switch_req, backup_ref_clock, primary_ref_clock};
		sync2_d = sync1_q;
		hist_d  = sync2_q;
	end

	// register the chain; no logic looks at the first stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// request seen high in every stage, so a rise needs a low first;
			// references low in every stage, so no false falling edge follows reset
			sync1_q <= 3'h4;
			sync2_q <= 3'h4;
			hist_q  <= 3'h4;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			hist_q  <= hist_d;
		end
	end

	logic [1:0] ref_rise;  // rising edges of both references
	logic [1:0] ref_fall;  // falling edges of both references
	logic       req_lvl;   // synchronised request level
	logic       req_rise;  // request rising edge

	assign ref_rise = sync2_q[1:0] & ~hist_q[1:0];
	assign ref_fall = ~sync2_q[1:0] & hist_q[1:0];
	assign req_lvl  = sync2_q[2];
	assign req_rise = sync2_q[2] & ~hist_q[2];

	////////////////////////////////////////////////////////////////////////////
	// reference activity monitors

	logic [`PLLSW_ALIVE_W-1:0] idle_q [2];   // cycles since last edge
	logic [`PLLSW_ALIVE_W-1:0] idle_d [2];
	logic [1:0]                alive;        // reference is toggling

	// restart on any edge, saturate at the window
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (ref_rise[i] | ref_fall[i]) begin
				idle_d[i] = '0;
			end else if (idle_q[i] != `PLLSW_ALIVE_W'(`PLLSW_ALIVE_CYC)) begin
				idle_d[i] = idle_q[i] + `PLLSW_ALIVE_W'(1);
			end else begin
				idle_d[i] = idle_q[i];
			end
			alive[i] = (idle_q[i] != `PLLSW_ALIVE_W'(`PLLSW_ALIVE_CYC));
		end
	end

	// start as dead so a switch cannot fire before edges were seen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_q[0] <= `PLLSW_ALIVE_W'(`PLLSW_ALIVE_CYC);
			idle_q[1] <= `PLLSW_ALIVE_W'(`PLLSW_ALIVE_CYC);
		end else begin
			idle_q <= idle_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// switchover sequencer

	pllsw_state_e state_q;   // sequence state
	pllsw_state_e state_d;
	logic [8:0]   held_q;    // reference cycles the request has been high
	logic [8:0]   held_d;
	logic         sel_q;     // selected reference
	logic         sel_d;
	logic         gate_q;    // counter reference enabled
	logic         gate_d;
	logic         ev_done;   // pulse: a switch completed
	logic         ev_stall;  // pulse: target found not toggling
	logic [`PLLSW_CTRL_DLY_W-1:0] dly_q; // configured switchover delay
	logic [8:0]   need;      // required held cycles

	// three reference cycles plus the configured delay
	assign need = `PLLSW_MIN_HOLD + {1'b0, dly_q};

	// next state of the sequence
	always_comb begin
		state_d  = state_q;
		held_d   = held_q;
		sel_d    = sel_q;
		gate_d   = gate_q;
		ev_done  = 1'b0;
		ev_stall = 1'b0;
		case (state_q)
			PLLSW_ARMED: begin
				held_d = '0;
				if (req_rise) begin
					state_d = PLLSW_COUNT;
				end
			end
			PLLSW_COUNT: begin
				// a short pulse aborts; counted on the active reference
				if (!req_lvl) begin
					state_d = PLLSW_ARMED;
				end else if (held_q >= need) begin
					if (pick(!sel_q, alive)) begin
						state_d = PLLSW_GATE;
					end else begin
						state_d  = PLLSW_WAIT;
						ev_stall = 1'b1;
					end
				end else if (pick(sel_q, ref_rise)) begin
					held_d = held_q + 9'h001;
				end
			end
			PLLSW_WAIT: begin
				// keep the current selection until the target toggles
				if (pick(!sel_q, alive)) begin
					state_d = PLLSW_GATE;
				end
			end
			PLLSW_GATE: begin
				// gate off on the old input's falling edge, or at once if dead
				if (pick(sel_q, ref_fall) || !pick(sel_q, alive)) begin
					gate_d  = 1'b0;
					state_d = PLLSW_SWAP;
				end
			end
			PLLSW_SWAP: begin
				// flip the mux on the new input's falling edge
				if (pick(!sel_q, ref_fall)) begin
					sel_d   = !sel_q;
					gate_d  = 1'b1;
					ev_done = 1'b1;
					state_d = PLLSW_HOLD;
				end
			end
			PLLSW_HOLD: begin
				// request left high causes nothing; low re-arms
				if (!req_lvl) begin
					state_d = PLLSW_ARMED;
				end
			end
			default: begin
				state_d = PLLSW_ARMED;
			end
		endcase
	end

	// register the sequence; primary selected and gated on from reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= PLLSW_ARMED;
			held_q  <= 9'h000;
			sel_q   <= 1'b0;
			gate_q  <= 1'b1;
		end else begin
			state_q <= state_d;
			held_q  <= held_d;
			sel_q   <= sel_d;
			gate_q  <= gate_d;
		end
	end

	assign ref_select   = sel_q;
	assign ref_gate_en  = gate_q;
	assign active_clock = sel_q;

	////////////////////////////////////////////////////////////////////////////
	// register file: control, status, interrupt status and mask

	logic [`PLLSW_CTRL_DLY_W-1:0] dly_d;
	logic [`PLLSW_IRQ_W-1:0]      ist_q;   // sticky interrupt status
	logic [`PLLSW_IRQ_W-1:0]      ist_d;
	logic [`PLLSW_IRQ_W-1:0]      imsk_q;  // interrupt mask, 1 enables
	logic [`PLLSW_IRQ_W-1:0]      imsk_d;
	pllsw_word_t                  rdat_q;  // read data register
	pllsw_word_t                  rdat_d;
	logic [`PLLSW_IRQ_W-1:0]      ev_vec;  // this cycle's events
	logic [`PLLSW_IRQ_W-1:0]      w1c;     // bits software clears

	assign ev_vec = {ev_stall, ev_done};

	// writes, write-one-to-clear and read mux
	always_comb begin
		dly_d  = dly_q;
		imsk_d = imsk_q;
		w1c    = '0;
		rdat_d = '0;
		if (reg_wr && hit(reg_addr, `PLLSW_CTRL_OFS)) begin
			dly_d = reg_wdata[`PLLSW_CTRL_DLY_LSB +: `PLLSW_CTRL_DLY_W];
		end
		if (reg_wr && hit(reg_addr, `PLLSW_IRQ_MASK_OFS)) begin
			imsk_d = reg_wdata[`PLLSW_IRQ_W-1:0];
		end
		if (reg_wr && hit(reg_addr, `PLLSW_IRQ_STAT_OFS)) begin
			w1c = reg_wdata[`PLLSW_IRQ_W-1:0];
		end
		// a new event wins over a clear in the same cycle
		ist_d = (ist_q & ~w1c) | ev_vec;
		if (reg_rd) begin
			// unmapped offsets read as zero
			if (hit(reg_addr, `PLLSW_CTRL_OFS)) begin
				rdat_d[`PLLSW_CTRL_DLY_LSB +: `PLLSW_CTRL_DLY_W] = dly_q;
			end else if (hit(reg_addr, `PLLSW_STATUS_OFS)) begin
				rdat_d[`PLLSW_ST_ACTIVE_BIT] = sel_q;
				rdat_d[`PLLSW_ST_WAIT_BIT]   = (state_q == PLLSW_WAIT);
				rdat_d[`PLLSW_ST_REQ_BIT]    = req_lvl;
				rdat_d[`PLLSW_ST_PRI_OK_BIT] = alive[0];
				rdat_d[`PLLSW_ST_BAK_OK_BIT] = alive[1];
			end else if (hit(reg_addr, `PLLSW_IRQ_STAT_OFS)) begin
				rdat_d[`PLLSW_IRQ_W-1:0] = ist_q;
			end else if (hit(reg_addr, `PLLSW_IRQ_MASK_OFS)) begin
				rdat_d[`PLLSW_IRQ_W-1:0] = imsk_q;
			end
		end
	end

	// register file state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_q  <= `PLLSW_CTRL_RST;
			ist_q  <= `PLLSW_IRQ_RST;
			imsk_q <= `PLLSW_IRQ_RST;
			rdat_q <= '0;
		end else begin
			dly_q  <= dly_d;
			ist_q  <= ist_d;
			imsk_q <= imsk_d;
			rdat_q <= rdat_d;
		end
	end

	assign reg_rdata = rdat_q;
	assign irq       = |(ist_q & imsk_q);

endmodule // pllsw_switchover

// >>> pllsw_monitor.sv
/* checker for the reference switchover block, bound to its ports.
 * assumes: reference periods of at least 10 clk, low phase over 4 clk. */
`timescale 1ns/1ps
`include "pllsw_regs.svh"
module pllsw_monitor (
	input wire logic                   clk,               // system clock
	input wire logic                   rst_n,             // async reset, active low
	input wire logic                   primary_ref_clock, // primary pin
	input wire logic                   backup_ref_clock,  // backup pin
	input wire logic                   switch_req,        // request pin
	input wire pllsw_pkg::pllsw_addr_t reg_addr,          // register address
	input wire pllsw_pkg::pllsw_word_t reg_wdata,         // write data
	input wire logic                   reg_wr,            // write strobe
	input wire logic                   reg_rd,            // read strobe
	input wire pllsw_pkg::pllsw_word_t reg_rdata,         // read data
	input wire logic                   ref_select,        // mux select
	input wire logic                   ref_gate_en,       // counter gate
	input wire logic                   active_clock,      // status
	input wire logic                   irq                // interrupt
);
	import pllsw_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	AST_SEL_AFTER_RST: assert property (!$past(rst_n) |-> !ref_select)
		else $error("select not primary after reset");
	AST_STATUS_MIRROR: assert property (active_clock == ref_select)
		else $error("status differs from select");
	AST_SWAP_GATED: assert property ($changed(ref_select) |-> !$past(ref_gate_en))
		else $error("select changed while gate open");
	AST_GATE_OLD_FALL: assert property ($fell(ref_gate_en) && !ref_select |-> !$past(primary_ref_clock, 2))
		else $error("gate closed off an old falling edge");
	AST_SWAP_NEW_FALL: assert property ($rose(ref_select) |-> !$past(backup_ref_clock, 2))
		else $error("swap off a new falling edge");
	// the gate may only stay shut for about one period of the new input
	AST_GATE_SHORT: assert property ($fell(ref_gate_en) |-> ##[1:40] ref_gate_en)
		else $error("gate shut too long");
	AST_REQ_HELD: assert property ($fell(ref_gate_en) |-> $past(switch_req, 24))
		else $error("switch began without a held request");
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	AST_IRQ_MASKED: assert property ($past(reg_wr) && $past(reg_addr) == `PLLSW_IRQ_MASK_OFS
		&& $past(reg_wdata) == 32'h0 |-> !irq) else $error("irq with all masked");
endmodule // pllsw_monitor
bind pllsw_switchover pllsw_monitor i_pllsw_monitor (.clk(clk), .rst_n(rst_n),
	.primary_ref_clock(primary_ref_clock), .backup_ref_clock(backup_ref_clock),
	.switch_req(switch_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_select(ref_select),
	.ref_gate_en(ref_gate_en), .active_clock(active_clock), .irq(irq));

// >>> pllsw_user_model.sv
/* far-side user logic: both reference clocks and the switch request.
 * assumes: the bench steers it through pri_run, bak_run and request(). */
`timescale 1ns/1ps
module pllsw_user_model #(
	parameter int PRI_HALF = 26, // primary half period, ns
	parameter int BAK_HALF = 61  // backup half period, ns, over twice slower
) (
	input  wire logic clk,               // system clock
	input  wire logic pri_run,           // primary toggles while high
	input  wire logic bak_run,           // backup toggles while high
	output logic      primary_ref_clock, // primary reference
	output logic      backup_ref_clock,  // backup reference
	input  wire logic active_clock,      // active reference from the block
	output logic      switch_req,        // manual request
	output logic      out_en             // loop outputs enabled
);
	initial {primary_ref_clock, backup_ref_clock, switch_req} = 3'b000;
	// a stopped input stands still, like a dead oscillator
	always #(PRI_HALF) if (pri_run) primary_ref_clock = ~primary_ref_clock;
	always #(BAK_HALF) if (bak_run) backup_ref_clock = ~backup_ref_clock;
	// manual requests only, failure flags never relied on
	// loop stub: a change of active input resets the loop 3 clk, 15 ns
	// outputs come back only once lock has stood 16 clk
	logic act_q = 1'b0;  // active input at the last edge
	int   rst_left = 0;  // loop reset cycles still to come
	int   lock_age = 0;  // cycles since the loop left reset, stands for lock
	always @(posedge clk) begin
		act_q <= active_clock;
		if (active_clock !== act_q) rst_left <= 3;
		else if (rst_left > 0) rst_left <= rst_left - 1;
		if (rst_left > 0) lock_age <= 0;
		else if (lock_age < 16) lock_age <= lock_age + 1;
	end
	assign out_en = (rst_left == 0) && (lock_age >= 16);
	// each call ends low, so the next is a fresh rising edge
	task automatic request(input int hold_ns);
		@(posedge clk) switch_req <= 1'b1;
		#(hold_ns);
		@(posedge clk) switch_req <= 1'b0;
		@(posedge clk);
	endtask
endmodule // pllsw_user_model

// >>> pllsw_switchover_tb_top.sv
/* self-checking bench for the switchover block against a small model.
 * assumes: the user model drives the pins, the checker binds itself. */
`timescale 1ns/1ps
`include "pllsw_regs.svh"
module pllsw_switchover_tb_top;
	import pllsw_pkg::*;
	localparam int PP = 52;  // primary period, ns
	localparam int BP = 122; // backup period, ns
	logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        pri_run = 1'b1, bak_run = 1'b1, ref_select, ref_gate_en, active_clock, irq;
	logic        primary_ref_clock, backup_ref_clock, switch_req, out_en;
	pllsw_addr_t reg_addr = 8'h00;
	pllsw_word_t reg_wdata = 32'h0, reg_rdata, rd;
	int          fail_count = 0, tests_run = 0, exp_sel = 0, dly, h, n;
	logic [31:0] seed = 32'h988c7fa5;
	always #2.5 clk = ~clk;
	pllsw_user_model #(.PRI_HALF(PP / 2), .BAK_HALF(BP / 2)) i_pllsw_user_model (.clk(clk),
		.pri_run(pri_run), .bak_run(bak_run), .primary_ref_clock(primary_ref_clock),
		.backup_ref_clock(backup_ref_clock), .switch_req(switch_req),
		.active_clock(active_clock), .out_en(out_en));
	pllsw_switchover i_pllsw_switchover (.clk(clk), .rst_n(rst_n),
		.primary_ref_clock(primary_ref_clock), .backup_ref_clock(backup_ref_clock),
		.switch_req(switch_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_select(ref_select),
		.ref_gate_en(ref_gate_en), .active_clock(active_clock), .irq(irq));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input pllsw_addr_t a, input pllsw_word_t d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdr(input pllsw_addr_t a, output pllsw_word_t d);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 1'b0;
		@(negedge clk) d = reg_rdata;
	endtask
	// status holds both alive bits, request low, and the model's selection
	task automatic model_chk(input string what);
		rdr(`PLLSW_STATUS_OFS, rd);
		chk(rd, 32'h18 | exp_sel, what);
		chk(active_clock, exp_sel[0], "active input");
		chk(ref_select, exp_sel[0], "mux select");
		chk(ref_gate_en, 1'b1, "gate open after switch");
		chk(out_en, 1'b1, "loop outputs back");
	endtask
	task automatic try_switch(input int cyc, input bit sw);
		int t;
		t = cyc * (exp_sel ? BP : PP);
		// a real switch is held at least three periods of the slower input
		if (sw && t < 3 * BP) t = 3 * BP;
		i_pllsw_user_model.request(t);
		repeat (80) @(posedge clk);
		if (sw) exp_sel ^= 1;
		model_chk("select after request");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		test_done;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(ref_select, 1'b0, "select at reset");
		repeat (300) @(posedge clk);
		model_chk("idle");
		rdr(8'h10, rd);
		chk(rd, 32'h0, "unmapped read");
		wr(`PLLSW_IRQ_MASK_OFS, 32'h3);
		rdr(`PLLSW_IRQ_MASK_OFS, rd);
		chk(rd, 32'h3, "mask readback");
		$display("test reset done");
		// random delay and hold, skipping the two counts on the edge of sync slack
		for (n = 0; n < 12; n++) begin
			seed = xs(seed);
			dly = seed[1:0];
			h = seed[11:8] % 10;
			if (h == 3 + dly || h == 4 + dly) h = 5 + dly;
			wr(`PLLSW_CTRL_OFS, dly);
			rdr(`PLLSW_CTRL_OFS, rd);
			chk(rd, dly, "delay readback");
			try_switch(h, h > 3 + dly);
		end
		$display("test random done");
		wr(`PLLSW_CTRL_OFS, 32'h0);
		try_switch(20, 1'b1);
		chk(irq, 1'b1, "irq after switch");
		wr(`PLLSW_IRQ_STAT_OFS, 32'h3);
		@(negedge clk);
		chk(irq, 1'b0, "irq cleared");
		$display("test hold done");
		// raise with both inputs toggling, then stop the target during a long
		// delay, so it is dead when the switch falls due
		wr(`PLLSW_CTRL_OFS, 32'h28);
		fork
			i_pllsw_user_model.request(12000);
			begin
				repeat (10) @(posedge clk);
				{pri_run, bak_run} <= exp_sel ? 2'b01 : 2'b10;
				repeat (1200) @(posedge clk);
				rdr(`PLLSW_STATUS_OFS, rd);
				chk(rd[1:0], {1'b1, exp_sel[0]}, "waiting on target");
				@(posedge clk) {pri_run, bak_run} <= 2'b11;
			end
		join
		repeat (80) @(posedge clk);
		exp_sel ^= 1;
		model_chk("switch after wait");
		rdr(`PLLSW_IRQ_STAT_OFS, rd);
		chk(rd, 32'h3, "done and stall flags");
		wr(`PLLSW_IRQ_MASK_OFS, 32'h0);
		@(negedge clk);
		chk(irq, 1'b0, "irq masked");
		$display("test stall done");
		test_done;
	end
endmodule // pllsw_switchover_tb_top
